/* File: rtl/sfr_pkg.sv */
/*
 Package for the serial flash interface rescue detector: frame lengths,
 sequence step states, interface mode encodings and carrier structs.
 Assumes a device core on core_clk and a serial link clock from the host.
*/
package sfr_pkg;

   // ==========================================================
   // Frame lengths in link clocks
   localparam int unsigned SFR_CNT_W      = 6;
   localparam logic [5:0]  SFR_STEP1_LEN0 = 6'h07;
   localparam logic [5:0]  SFR_STEP1_LEN1 = 6'h09;
   localparam logic [5:0]  SFR_STEP1_LEN2 = 6'h0D;
   localparam logic [5:0]  SFR_STEP1_LEN3 = 6'h11;
   localparam logic [5:0]  SFR_STEP1_LEN4 = 6'h19;
   localparam logic [5:0]  SFR_STEP1_LEN5 = 6'h21;
   localparam logic [5:0]  SFR_LOSS_LEN   = 6'h08;
   localparam logic [5:0]  SFR_RESCUE_LEN = 6'h10;
   localparam logic [5:0]  SFR_CNT_MAX    = 6'h3F;

   // ==========================================================
   // Deselect time, informative for the host
   localparam int unsigned SFR_MIN_DESELECT_NS = 50;
   localparam int unsigned SFR_CLK_PERIOD_NS   = 10;
   localparam int unsigned SFR_MIN_DESELECT_CYC =
      (SFR_MIN_DESELECT_NS + SFR_CLK_PERIOD_NS - 1) / SFR_CLK_PERIOD_NS;

   // ==========================================================
   // Interface modes
   typedef enum logic [1:0]
   {
      SFR_PROTO_SINGLE = 2'h0,
      SFR_PROTO_DUAL   = 2'h1,
      SFR_PROTO_QUAD   = 2'h2
   } sfr_proto_t;

   // Sequence progress, Gray along the path
   typedef enum logic [2:0]
   {
      SFR_S_IDLE = 3'h0,
      SFR_S_F1   = 3'h1,
      SFR_S_F2   = 3'h3,
      SFR_S_F3   = 3'h2,
      SFR_S_F4   = 3'h6,
      SFR_S_F5   = 3'h7,
      SFR_S_STEP2 = 3'h5
   } sfr_step_t;

   // Interface configuration
   typedef struct packed
   {
      sfr_proto_t proto;
      logic       dtr;
      logic       execute_in_place_mode;
   } sfr_cfg_t;

   localparam sfr_cfg_t SFR_CFG_RESET = '{SFR_PROTO_SINGLE, 1'b0, 1'b0};

   // Frame report from link domain
   typedef struct packed
   {
      logic [5:0] count;
      logic       lines_high;
   } sfr_frame_t;

endpackage

/* File: rtl/sfr_rescue.sv */
/*
 Recovery sequence detector for the serial flash interface.
 Link side counts link clocks under select low; core side tracks steps
 and drives the interface configuration. Assumes select frames the link
 clock and the host keeps step order and deselect time.
*/
`timescale 1ns/1ps

module sfr_rescue
   import sfr_pkg::*;
(
   input  wire logic     core_clk,
   input  wire logic     resetn,
   input  wire logic     link_clk,
   input  wire logic     select_n,
   input  wire logic     serial_line_zero,
   input  wire logic     serial_line_three,
   input  wire sfr_cfg_t stored_cfg,
   input  wire logic     power_up_undefined,
   input  wire sfr_cfg_t undefined_cfg,
   output sfr_cfg_t      active_cfg,
   output logic          loss_recovered,
   output logic          rescue_done,
   output logic          interface_reset
);

   // ==========================================================
   // Link domain: count and capture
   typedef struct packed
   {
      logic [5:0] count;
      logic       lines_high;
   } sfr_link_st_t;

   sfr_link_st_t lk;
   sfr_link_st_t next_lk;

   always_comb
   begin
      next_lk = lk;
      if (lk.count != SFR_CNT_MAX)
      begin
         next_lk.count = lk.count + 6'h01;
      end
      next_lk.lines_high = lk.lines_high & serial_line_zero & serial_line_three;
   end

   // Edges only during a frame; select high clears count and presets lines high before the next frame
   always_ff @(posedge link_clk or posedge select_n)
   begin
      if (select_n)
      begin
         lk.count      <= 6'h00;
         lk.lines_high <= 1'b1;
      end
      else
      begin
         lk.count      <= next_lk.count;
         lk.lines_high <= next_lk.lines_high;
      end
   end

   // ==========================================================
   // Select-edge capture of the closed frame
   typedef struct packed
   {
      sfr_frame_t frame;
      logic       toggle;
   } sfr_cap_st_t;

   sfr_cap_st_t  cap;
   sfr_cap_st_t  next_cap;

   always_comb
   begin
      next_cap.frame.count      = lk.count;
      next_cap.frame.lines_high = lk.lines_high;
      next_cap.toggle           = ~cap.toggle;
   end

   // Select rise closes the frame; snapshot and toggle across
   always_ff @(posedge select_n or negedge resetn)
   begin
      if (!resetn)
      begin
         cap <= '0;
      end
      else
      begin
         cap <= next_cap;
      end
   end

   // ==========================================================
   // Core domain state
   typedef struct packed
   {
      logic [2:0] tog_sync;
      sfr_step_t  step;
      sfr_cfg_t   cfg;
      logic       init_done;
      logic       loss_recovered;
      logic       rescue_done;
      logic       interface_reset;
   } sfr_core_st_t;

   sfr_core_st_t st;
   sfr_core_st_t next_st;
   logic         frame_evt;
   sfr_frame_t   fr;
   logic         ok1;
   logic         loss_frame;
   logic         rescue_frame;
   logic         restart_frame;

   assign frame_evt = st.tog_sync[2] ^ st.tog_sync[1];
   assign fr        = cap.frame;

   // Second-step and restart decodes of the closed frame
   assign loss_frame    = (st.step == SFR_S_STEP2) & fr.lines_high
                          & (fr.count == SFR_LOSS_LEN);
   assign rescue_frame  = (st.step == SFR_S_STEP2) & fr.lines_high
                          & (fr.count == SFR_RESCUE_LEN);
   assign restart_frame = fr.lines_high & (fr.count == SFR_STEP1_LEN0);

   always_comb
   begin
      next_st                 = st;
      next_st.tog_sync        = {st.tog_sync[1:0], cap.toggle};
      next_st.rescue_done     = 1'b0;
      next_st.interface_reset = 1'b0;
      ok1 = 1'b0;
      if (!st.init_done)
      begin
         next_st.init_done = 1'b1;
         next_st.cfg       = power_up_undefined ? undefined_cfg : stored_cfg;
      end
      else if (frame_evt)
      begin
         unique case (st.step)
            SFR_S_IDLE:  ok1 = fr.count == SFR_STEP1_LEN0;
            SFR_S_F1:    ok1 = fr.count == SFR_STEP1_LEN1;
            SFR_S_F2:    ok1 = fr.count == SFR_STEP1_LEN2;
            SFR_S_F3:    ok1 = fr.count == SFR_STEP1_LEN3;
            SFR_S_F4:    ok1 = fr.count == SFR_STEP1_LEN4;
            SFR_S_F5:    ok1 = fr.count == SFR_STEP1_LEN5;
            SFR_S_STEP2: ok1 = 1'b0;
            default:     ok1 = 1'b0;
         endcase
         ok1 = ok1 & fr.lines_high;
         if (ok1)
         begin
            unique case (st.step)
               SFR_S_IDLE: next_st.step = SFR_S_F1;
               SFR_S_F1:   next_st.step = SFR_S_F2;
               SFR_S_F2:   next_st.step = SFR_S_F3;
               SFR_S_F3:   next_st.step = SFR_S_F4;
               SFR_S_F4:   next_st.step = SFR_S_F5;
               default:
               begin
                  next_st.step = SFR_S_STEP2;
                  next_st.cfg.execute_in_place_mode = 1'b0;
               end
            endcase
         end
         else if (loss_frame)
         begin
            next_st.step           = SFR_S_IDLE;
            next_st.cfg            = SFR_CFG_RESET;
            next_st.loss_recovered = 1'b1;
         end
         else if (rescue_frame)
         begin
            next_st.step            = SFR_S_IDLE;
            next_st.cfg             = stored_cfg;
            next_st.cfg.proto       = SFR_PROTO_SINGLE;
            next_st.cfg.execute_in_place_mode = 1'b0;
            next_st.rescue_done     = 1'b1;
            next_st.interface_reset = 1'b1;
         end
         else
         begin
            next_st.step = restart_frame ? SFR_S_F1 : SFR_S_IDLE;
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st <= '{3'h0, SFR_S_IDLE, SFR_CFG_RESET, 1'b0, 1'b0, 1'b0, 1'b0};
      end
      else
      begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Outputs
   assign active_cfg      = st.cfg;
   assign loss_recovered  = st.loss_recovered;
   assign rescue_done     = st.rescue_done;
   assign interface_reset = st.interface_reset;

endmodule

/* File: sim/sfr_rescue_props.sv */
/* Checker for the rescue detector outputs.
 Assumes it is bound to sfr_rescue. */
`timescale 1ns/1ps
module sfr_rescue_props
   import sfr_pkg::*;
(
   input wire logic     core_clk,
   input wire logic     resetn,
   input wire logic     select_n,
   input wire sfr_cfg_t stored_cfg,
   input wire sfr_cfg_t active_cfg,
   input wire logic     loss_recovered,
   input wire logic     rescue_done,
   input wire logic     interface_reset
);
   // ==========================================
   // Output relations
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   sequence s_idle;
      select_n && $past(select_n, 2);
   endsequence
   sequence s_single;
      active_cfg.proto == SFR_PROTO_SINGLE && !active_cfg.execute_in_place_mode;
   endsequence
   chk_pulse_pair: assert property (interface_reset == rescue_done) else $error("pair");
   chk_pulse_width: assert property (rescue_done |=> !rescue_done) else $error("width");
   chk_loss_kept: assert property (loss_recovered |=> loss_recovered) else $error("kept");
   chk_loss_single: assert property (loss_recovered |-> s_single) else $error("loss");
   chk_rescue_single: assert property (rescue_done |-> s_single) else $error("single");
   chk_rescue_dtr: assert property (rescue_done |-> active_cfg.dtr == stored_cfg.dtr)
      else $error("dtr");
   chk_done_frame: assert property (rescue_done |-> s_idle) else $error("done");
   chk_loss_frame: assert property ($rose(loss_recovered) |-> s_idle) else $error("rose");
endmodule
bind sfr_rescue sfr_rescue_props u_props (.core_clk(core_clk), .resetn(resetn),
   .select_n(select_n), .stored_cfg(stored_cfg), .active_cfg(active_cfg),
   .loss_recovered(loss_recovered), .rescue_done(rescue_done),
   .interface_reset(interface_reset));

/* File: sim/sfr_host.sv */
/* Host model driving recovery frames.
 Assumes core_clk paces the frames. */
`timescale 1ns/1ps
module sfr_host
(
   input  wire logic core_clk,
   output logic      link_clk,
   output logic      select_n,
   output logic      line_zero,
   output logic      line_three
);
   // ==========================================
   // Frame driver
   initial
   begin
      {link_clk, select_n, line_zero, line_three} = 4'h4;
   end
   task automatic frame(input int n, input logic high);
      @(posedge core_clk);
      select_n <= 1'b0;
      line_zero <= 1'b1;
      line_three <= high;
      repeat (n)
      begin
         #3 link_clk = 1'b1;
         #3 link_clk = 1'b0;
      end
      @(posedge core_clk);
      select_n <= 1'b1;
      line_zero <= 1'b0;
      line_three <= ~high;
      repeat (6) @(posedge core_clk);
   endtask
   task automatic step_one(input int bad);
      int len [6] = '{7, 9, 13, 17, 25, 33};
      for (int i = 0; i < 6; i++)
         frame(len[i] - (i == bad), 1'b1);
   endtask
endmodule

/* File: sim/sfr_rescue_tb.sv */
/* Self-checking bench for the rescue detector.
 Assumes the host model and the bound checker. */
`timescale 1ns/1ps
module sfr_rescue_tb;
   import sfr_pkg::*;
   logic     core_clk = 1'b0;
   logic     resetn   = 1'b0;
   logic     link_clk, select_n, line_zero, line_three;
   logic     loss_recovered, rescue_done, interface_reset;
   sfr_cfg_t active_cfg;
   sfr_cfg_t stored   = {SFR_PROTO_DUAL, 2'h3};
   sfr_cfg_t bad_cfg  = {SFR_PROTO_QUAD, 2'h1};
   logic     pwr_undef = 1'b1;
   int       err_total   = 0;
   int       comparisons = 0;
   // ==========================================
   // Harness
   always #5 core_clk = ~core_clk;
   sfr_host h (.core_clk(core_clk), .link_clk(link_clk), .select_n(select_n),
      .line_zero(line_zero), .line_three(line_three));
   sfr_rescue DUT (.core_clk(core_clk), .resetn(resetn), .link_clk(link_clk),
      .select_n(select_n), .serial_line_zero(line_zero), .serial_line_three(line_three),
      .stored_cfg(stored), .power_up_undefined(pwr_undef), .undefined_cfg(bad_cfg),
      .active_cfg(active_cfg), .loss_recovered(loss_recovered),
      .rescue_done(rescue_done), .interface_reset(interface_reset));
   task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic watch(input int n, output logic [1:0] seen, output sfr_cfg_t cfg);
      seen = 2'h0;
      cfg = active_cfg;
      repeat (n)
      begin
         @(negedge core_clk);
         if (rescue_done === 1'b1)
            {seen, cfg} = {1'b1, interface_reset, active_cfg};
      end
   endtask
   task automatic t_rescue;
      logic [1:0] seen;
      sfr_cfg_t cfg;
      cmp(active_cfg, bad_cfg);
      h.step_one(9);
      cmp({3'h0, active_cfg.execute_in_place_mode}, 4'h0);
      fork
         h.frame(16, 1'b1);
         watch(20, seen, cfg);
      join
      cmp({2'h0, seen}, 4'h3);
      cmp(cfg, {SFR_PROTO_SINGLE, 2'h2});
      cmp({3'h0, loss_recovered}, 4'h0);
      $display("t_rescue end");
   endtask
   task automatic t_loss;
      h.step_one(9);
      h.frame(8, 1'b1);
      cmp({3'h0, loss_recovered}, 4'h1);
      cmp({active_cfg.proto, active_cfg.execute_in_place_mode}, 4'h0);
      $display("t_loss end");
   endtask
   task automatic t_refuse;
      logic [1:0] seen;
      sfr_cfg_t cfg;
      fork
         begin
            h.frame(16, 1'b1);
            h.step_one(2);
            h.frame(16, 1'b1);
            h.step_one(9);
            h.frame(15, 1'b1);
            h.step_one(9);
            h.frame(16, 1'b0);
         end
         watch(900, seen, cfg);
      join
      cmp({2'h0, seen}, 4'h0);
      $display("t_refuse end");
   endtask
   task automatic t_power;
      logic [1:0] seen;
      sfr_cfg_t   cfg;
      @(posedge core_clk);
      resetn    <= 1'b0;
      pwr_undef <= 1'b0;
      stored    <= {SFR_PROTO_DUAL, 2'h0};
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge core_clk);
      cmp(active_cfg, {SFR_PROTO_DUAL, 2'h0});
      cmp({3'h0, loss_recovered}, 4'h0);
      h.step_one(9);
      fork
         h.frame(16, 1'b1);
         watch(20, seen, cfg);
      join
      cmp({2'h0, seen}, 4'h3);
      cmp(cfg, {SFR_PROTO_SINGLE, 2'h0});
      $display("t_power end");
   endtask
   task automatic complete_run;
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge core_clk);
      t_rescue;
      t_loss;
      t_refuse;
      t_power;
      complete_run;
   end
   initial
   begin
      #100000;
      err_total++;
      complete_run;
   end
endmodule
